/* core/ssof_map.svh */
// Constants for the servo status flag block: widths, codes, timing counts.
// Assumes a 100 MHz system clock.
`ifndef SSOF_MAP_SVH
`define SSOF_MAP_SVH
`define SSOF_CLK_MHZ         100
`define SSOF_POS_W           32
`define SSOF_SPD_W           16
`define SSOF_NC_HOLD_MS      1500
`define SSOF_NC_HOLD_CYC     (`SSOF_NC_HOLD_MS * 1000 * `SSOF_CLK_MHZ)
`define SSOF_BRK_UNIT_CYC    32'h0001_86a0
`define SSOF_LAST_ENTRY      4'hf
`define SSOF_TQSEL_STEP      1'b1
`define SSOF_FMT_POINT       2'h0
`define SSOF_FMT_POS         2'h1
`define SSOF_FMT_NEG         2'h2
`define SSOF_POS_MAX         32'h7fff_ffff
`define SSOF_A_CTRL          32'h0000_0000
`define SSOF_A_SPDLIM        32'h0000_0004
`define SSOF_A_TQSPD         32'h0000_0008
`define SSOF_A_ZWIDTH        32'h0000_000c
`define SSOF_A_ZSPD          32'h0000_0010
`define SSOF_A_PT1           32'h0000_0014
`define SSOF_A_PT2           32'h0000_0018
`define SSOF_A_PTW           32'h0000_001c
`define SSOF_A_HOME          32'h0000_0020
`define SSOF_A_HRANGE        32'h0000_0024
`define SSOF_A_SOT           32'h0000_0028
`define SSOF_A_BRKDLY        32'h0000_002c
`define SSOF_A_STATUS        32'h0000_0030
`define SSOF_A_ENDMARK       32'h0000_0034
`endif

/* core/ssof_pkg.sv */
// Types for the servo status flag block.
// Assumes ssof_map.svh constants.
package ssof_pkg;
   typedef enum logic [1:0] {
      CM_POSITION = 2'b00,
      CM_SPEED    = 2'b01,
      CM_TORQUE   = 2'b10
   } ssof_mode_t;
   typedef enum logic [1:0] {
      BR_OFF  = 2'b00,
      BR_ON   = 2'b01,
      BR_HOLD = 2'b10
   } ssof_brk_t;
   typedef struct packed {
      logic [31:0] position;
      logic [31:0] command;
      logic [15:0] speed;
      logic        dirPos;
      logic        moving;
      logic        inPosition;
      logic        homed;
      logic        pulseOp;
      logic        intPos;
   } ssof_motion_t;
   typedef struct packed {
      logic speedLimit;
      logic overwrite;
      logic brake;
      logic alarmNo;
      logic alarmNc;
      logic area1;
      logic area2;
      logic limiter;
      logic overtravel;
      logic cycleEnd;
      logic homeDone;
      logic zeroDev;
      logic zeroSpeed;
      logic ready;
      logic baseEnable;
      logic rapidDecel;
   } ssof_flags_t;
endpackage

/* core/ssof_status_flags.sv */
// Servo status flag logic with APB register slave.
// Assumes motion values from the servo loops on the same clock; pins are raw.
`timescale 1ns/100ps
`include "ssof_map.svh"
module ssof_status_flags #(
   parameter int unsigned NC_HOLD_CYC = `SSOF_NC_HOLD_CYC
) (
   input  wire logic                  clock,
   input  wire logic                  rst,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [31:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire ssof_pkg::ssof_motion_t motion,
   input  wire ssof_pkg::ssof_mode_t   ctrlMode,
   input  wire logic [15:0]           multistepSpeed,
   input  wire logic                  teachActive,
   input  wire logic                  teachWritten,
   input  wire logic                  protectEvent,
   input  wire logic                  servoCtrlReady,
   input  wire logic                  seqStart,
   input  wire logic [3:0]            startAddr,
   input  wire logic                  pulseRatioOn,
   input  wire logic                  homingRun,
   input  wire logic                  servoOnPin,
   input  wire logic                  forcedStopPin,
   input  wire logic                  freeRunPin,
   input  wire logic                  mainPowerPin,
   input  wire logic                  alarmResetPin,
   input  wire logic                  otPosPin,
   input  wire logic                  otNegPin,
   output ssof_pkg::ssof_flags_t       flags,
   output logic                       limitStop,
   output logic [3:0]                 seqEntry
);
   // Configuration registers
   logic [31:0] ctrl_q, spdLim_q, tqSpd_q, zWidth_q, zSpd_q, pt1_q, pt2_q, ptw_q;
   logic [31:0] home_q, hRange_q, sot_q, brkDly_q, endMark_q;
   wire         selTqStep = ctrl_q[0];
   wire  [1:0]  areaFmt   = ctrl_q[2:1];
   wire         seqEnable = ctrl_q[3];
   wire         intData   = ctrl_q[4];
   wire  [15:0] contMap   = ctrl_q[31:16];

   // Pin synchronisers: three stages, change taken when last two agree
   localparam int NPIN = 7;
   wire  [NPIN-1:0] pinRaw = {otNegPin, otPosPin, alarmResetPin, mainPowerPin,
                              freeRunPin, forcedStopPin, servoOnPin};
   logic [NPIN-1:0] s1_q, s2_q, s3_q, pin_q;
   genvar g;
   generate
      for (g = 0; g < NPIN; g++)
      begin : g_sync
         always_ff @(posedge clock)
         begin
            if (rst)
            begin
               s1_q[g]  <= 1'b0;
               s2_q[g]  <= 1'b0;
               s3_q[g]  <= 1'b0;
               pin_q[g] <= 1'b0;
            end
            else
            begin
               s1_q[g] <= pinRaw[g];
               s2_q[g] <= s1_q[g];
               s3_q[g] <= s2_q[g];
               if (s2_q[g] == s3_q[g])
                  pin_q[g] <= s3_q[g];
            end
         end
      end
   endgenerate
   wire servoOn = pin_q[0];
   wire forcedStopOk = pin_q[1];
   wire freeRun = pin_q[2];
   wire mainPower = pin_q[3];
   wire alarmReset = pin_q[4];
   wire otPosOk = pin_q[5];
   wire otNegOk = pin_q[6];

   // APB slave, zero wait states
   wire        apbWr  = psel & penable & pwrite;
   wire        apbRd  = psel & ~penable & ~pwrite;
   wire [31:0] addr   = {paddr[31:2], 2'b00};
   wire        mapped = (addr <= `SSOF_A_ENDMARK);

   // Alarm latch
   logic alarm_q, rstSeen_q;
   wire  alarmRise = alarmReset & ~rstSeen_q;
   wire  alarm_d   = protectEvent | (alarm_q & ~alarmRise);

   // Normally-closed hold-off after power-up
   logic [31:0] ncCnt_q;
   wire         ncHold = (ncCnt_q < NC_HOLD_CYC);

   // Speed flags
   wire [15:0] spdMag  = motion.speed[15] ? 16'(-motion.speed) : motion.speed;
   wire [15:0] tqLimit = (selTqStep == `SSOF_TQSEL_STEP) ? multistepSpeed : tqSpd_q[15:0];
   wire [15:0] actLim  = (ctrlMode == ssof_pkg::CM_TORQUE) ? tqLimit : spdLim_q[15:0];
   wire        spdHit  = (spdMag >= actLim);
   wire        zSpdHit = (spdMag <= zSpd_q[15:0]);

   // Position differences
   wire [31:0] devRaw = motion.command - motion.position;
   wire [31:0] devMag = devRaw[31] ? 32'(-devRaw) : devRaw;
   wire        zDevHit = (devMag <= zWidth_q);
   wire [31:0] hRaw = motion.position - home_q;
   wire [31:0] hMag = hRaw[31] ? 32'(-hRaw) : hRaw;
   wire        hAny = (hRange_q == 32'h0) | (hRange_q == `SSOF_POS_MAX);
   wire        homeIn = motion.homed & (hAny | (hMag <= hRange_q));

   // Area detection, generated per area
   wire [31:0] areaSet [2];
   assign areaSet[0] = pt1_q;
   assign areaSet[1] = pt2_q;
   logic [1:0] areaHit;
   generate
      for (g = 0; g < 2; g++)
      begin : g_area
         wire [31:0] d  = motion.position - areaSet[g];
         wire [31:0] dm = d[31] ? 32'(-d) : d;
         wire above = $signed(motion.position) > $signed(areaSet[g]);
         assign areaHit[g] = motion.homed &
            ((areaFmt == `SSOF_FMT_POINT) ? (dm <= ptw_q) :
             (areaFmt == `SSOF_FMT_POS) ? above :
             (areaFmt == `SSOF_FMT_NEG) ? ~above : 1'b0);
      end
   endgenerate

   // Software limiter and overtravel
   wire limActive = (ctrlMode == ssof_pkg::CM_POSITION) & motion.homed & ~motion.intPos;
   wire atSoft = motion.dirPos ? ($signed(motion.position) >= $signed(sot_q))
                               : ($signed(motion.position) <= -$signed(sot_q));
   wire hwOt = (motion.dirPos & ~otPosOk) | (~motion.dirPos & ~otNegOk);
   wire otHit = hwOt | (motion.homed & atSoft);
   logic limTrip_q, limDir_q;
   wire  limReverse = limTrip_q & motion.moving & (motion.dirPos != limDir_q);

   // Sequential cycle end
   logic [3:0] entry_q;
   logic       cycEnd_q;
   wire        seqOn = seqEnable & intData;
   wire        seqKill = ~servoOn | pulseRatioOn | homingRun | otHit;
   function automatic logic [3:0] nextEntry(input logic [3:0] e, input logic [15:0] cm);
      logic [3:0] n;
      n = e;
      for (int i = 0; i < 16; i++)
         if (n != `SSOF_LAST_ENTRY && cm[n])
            n = n + 4'h1;
      if (n != `SSOF_LAST_ENTRY)
         n = n + 4'h1;
      return n;
   endfunction
   wire [3:0] startEntry = (startAddr == 4'h0) ? nextEntry(entry_q, contMap) : startAddr;
   wire       atEnd = endMark_q[entry_q] | (entry_q == `SSOF_LAST_ENTRY);

   // Brake / ready sequencing
   ssof_pkg::ssof_brk_t brk_q;
   logic [31:0] brkCnt_q;
   wire  readyCond = servoOn & forcedStopOk & ~freeRun & ~alarm_q & servoCtrlReady & mainPower;
   wire  hardDrop = alarm_q | ~mainPower;
   wire [31:0] brkLimit = 32'(brkDly_q * `SSOF_BRK_UNIT_CYC);

   logic [31:0] rd;
   always_comb
   begin
      case (addr)
         `SSOF_A_CTRL:    rd = ctrl_q;
         `SSOF_A_SPDLIM:  rd = spdLim_q;
         `SSOF_A_TQSPD:   rd = tqSpd_q;
         `SSOF_A_ZWIDTH:  rd = zWidth_q;
         `SSOF_A_ZSPD:    rd = zSpd_q;
         `SSOF_A_PT1:     rd = pt1_q;
         `SSOF_A_PT2:     rd = pt2_q;
         `SSOF_A_PTW:     rd = ptw_q;
         `SSOF_A_HOME:    rd = home_q;
         `SSOF_A_HRANGE:  rd = hRange_q;
         `SSOF_A_SOT:     rd = sot_q;
         `SSOF_A_BRKDLY:  rd = brkDly_q;
         `SSOF_A_STATUS:  rd = {12'h0, entry_q, flags};
         `SSOF_A_ENDMARK: rd = endMark_q;
         default:         rd = 32'h0;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         {ctrl_q, spdLim_q, tqSpd_q, zWidth_q, zSpd_q, pt1_q, pt2_q} <= '0;
         {ptw_q, home_q, hRange_q, sot_q, brkDly_q, endMark_q} <= '0;
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         if (apbRd)
            prdata <= rd;
         if (apbWr & mapped)
         begin
            case (addr)
               `SSOF_A_CTRL:    ctrl_q <= pwdata;
               `SSOF_A_SPDLIM:  spdLim_q <= pwdata;
               `SSOF_A_TQSPD:   tqSpd_q <= pwdata;
               `SSOF_A_ZWIDTH:  zWidth_q <= pwdata;
               `SSOF_A_ZSPD:    zSpd_q <= pwdata;
               `SSOF_A_PT1:     pt1_q <= pwdata;
               `SSOF_A_PT2:     pt2_q <= pwdata;
               `SSOF_A_PTW:     ptw_q <= pwdata;
               `SSOF_A_HOME:    home_q <= pwdata;
               `SSOF_A_HRANGE:  hRange_q <= pwdata;
               `SSOF_A_SOT:     sot_q <= pwdata;
               `SSOF_A_BRKDLY:  brkDly_q <= pwdata;
               `SSOF_A_ENDMARK: endMark_q <= pwdata;
               default:         ;
            endcase
         end
      end
   end

   // Protection state
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         alarm_q   <= 1'b0;
         rstSeen_q <= 1'b0;
         ncCnt_q   <= 32'h0;
         limTrip_q <= 1'b0;
         limDir_q  <= 1'b0;
      end
      else
      begin
         alarm_q   <= alarm_d;
         rstSeen_q <= alarmReset;
         if (ncHold)
            ncCnt_q <= ncCnt_q + 32'h1;
         if (limActive & atSoft & ~limTrip_q)
         begin
            limTrip_q <= 1'b1;
            limDir_q  <= motion.dirPos;
         end
         else if (limReverse)
            limTrip_q <= 1'b0;
      end
   end

   // Sequential positioning
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         entry_q  <= 4'h0;
         cycEnd_q <= 1'b0;
      end
      else
      begin
         if (seqStart)
         begin
            entry_q  <= startEntry;
            cycEnd_q <= 1'b0;
         end
         else if (~seqOn | seqKill)
            cycEnd_q <= 1'b0;
         else if (atEnd & motion.inPosition)
            cycEnd_q <= 1'b1;
      end
   end

   // Brake / ready state machine
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         brk_q    <= ssof_pkg::BR_OFF;
         brkCnt_q <= 32'h0;
      end
      else
      begin
         case (brk_q)
            ssof_pkg::BR_OFF:
               if (readyCond)
                  brk_q <= ssof_pkg::BR_ON;
            ssof_pkg::BR_ON:
               if (hardDrop)
                  brk_q <= ssof_pkg::BR_OFF;
               else if (~servoOn)
               begin
                  brk_q    <= ssof_pkg::BR_HOLD;
                  brkCnt_q <= 32'h0;
               end
            ssof_pkg::BR_HOLD:
               if (hardDrop | (brkCnt_q + 32'h1 >= brkLimit))
                  brk_q <= ssof_pkg::BR_OFF;
               else
                  brkCnt_q <= brkCnt_q + 32'h1;
            default:
               brk_q <= ssof_pkg::BR_OFF;
         endcase
      end
   end

   // Output flags, registered
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         flags     <= '0;
         limitStop <= 1'b0;
         seqEntry  <= 4'h0;
      end
      else
      begin
         flags.speedLimit <= spdHit;
         flags.overwrite  <= teachActive & (teachWritten | flags.overwrite);
         flags.brake      <= (brk_q == ssof_pkg::BR_ON) & readyCond & ~hardDrop;
         flags.alarmNo    <= alarm_d;
         flags.alarmNc    <= ~alarm_d & ~ncHold;
         flags.area1      <= areaHit[0];
         flags.area2      <= areaHit[1];
         flags.limiter    <= limTrip_q & ~limReverse & motion.inPosition;
         flags.overtravel <= otHit;
         flags.cycleEnd   <= cycEnd_q & ~seqKill;
         flags.homeDone   <= homeIn;
         if (ctrlMode == ssof_pkg::CM_POSITION)
            flags.zeroDev <= zDevHit;
         flags.zeroSpeed  <= zSpdHit;
         flags.ready      <= ((brk_q == ssof_pkg::BR_HOLD) | ((brk_q == ssof_pkg::BR_ON) & readyCond)) & ~hardDrop;
         flags.baseEnable <= (brk_q == ssof_pkg::BR_ON) & ~hardDrop;
         flags.rapidDecel <= limActive & atSoft & motion.pulseOp;
         limitStop        <= limActive & atSoft & ~limReverse;
         seqEntry         <= entry_q;
      end
   end

   chk_alarm_hold_sticky: assert property (@(posedge clock) disable iff (rst)
      $rose(alarm_q) ##1 (~alarmReset [*2]) |-> alarm_q)
      else $error("alarm cleared without reset edge");
   chk_alarm_drop_outputs: assert property (@(posedge clock) disable iff (rst)
      alarm_q |=> (~flags.baseEnable & ~flags.ready & ~flags.brake))
      else $error("alarm did not drop drive outputs");
   chk_power_drop_outputs: assert property (@(posedge clock) disable iff (rst)
      ~mainPower |=> ~flags.ready & ~flags.baseEnable)
      else $error("power loss left ready or base on");
   chk_nc_hold_time: assert property (@(posedge clock) disable iff (rst)
      ncHold |=> ~flags.alarmNc)
      else $error("closed alarm active during hold");
   chk_zero_speed_flag: assert property (@(posedge clock) disable iff (rst)
      ~$past(rst) |-> flags.zeroSpeed == $past(spdMag <= zSpd_q[15:0]))
      else $error("zero speed mismatch");
   chk_zero_dev_hold: assert property (@(posedge clock) disable iff (rst)
      (ctrlMode != ssof_pkg::CM_POSITION) |=> $stable(flags.zeroDev))
      else $error("zero deviation changed outside position mode");
   chk_area_needs_home: assert property (@(posedge clock) disable iff (rst)
      ~motion.homed |=> ~flags.area1 & ~flags.area2)
      else $error("area flag before homing");
   chk_cycle_end_marker_suppress: assert property (@(posedge clock) disable iff (rst)
      seqKill |=> ~flags.cycleEnd)
      else $error("cycle end while suppressed");
   chk_brake_servo_off: assert property (@(posedge clock) disable iff (rst)
      (brk_q == ssof_pkg::BR_HOLD) |=> ~flags.brake)
      else $error("brake released during hold");
   chk_ot_pins: assert property (@(posedge clock) disable iff (rst)
      (motion.dirPos & ~otPosOk) |=> flags.overtravel)
      else $error("positive overtravel missed");
endmodule // ssof_status_flags

/* verification/ssof_host_model.sv */
// Host controller model: drives servo-on and the alarm-clear pin.
// Assumes requests from the bench on the same clock as the drive.
`timescale 1ns/100ps
module ssof_host_model (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic reqServoOn,
   input  wire logic reqAlarmClear,
   input  wire logic alarmSeen,
   output logic      servoOnPin,
   output logic      alarmResetPin
);
   logic [2:0] pulseCnt_q;
   wire        startPulse = reqAlarmClear && alarmSeen && (pulseCnt_q == 3'h0);
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         pulseCnt_q <= 3'h0;
         servoOnPin <= 1'b0;
      end
      else
      begin
         pulseCnt_q <= startPulse ? 3'h6 : pulseCnt_q - {2'h0, pulseCnt_q != 3'h0};
         servoOnPin <= reqServoOn;
      end
   end
   // Clear only while an alarm shows; wide enough for the pin synchroniser
   assign alarmResetPin = (pulseCnt_q != 3'h0);
endmodule // ssof_host_model

/* verification/tb_top.sv */
// Self-checking bench for the servo status flag block.
// Assumes ssof_host_model beside it and a short closed-contact hold-off.
`timescale 1ns/100ps
`include "ssof_map.svh"
module tb_top;
   logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err, limitStop;
   logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
   ssof_pkg::ssof_motion_t mot = '0;
   ssof_pkg::ssof_mode_t   mode = ssof_pkg::CM_POSITION;
   ssof_pkg::ssof_flags_t  flags;
   logic [15:0] ms = 0;
   logic teachActive = 0, teachWritten = 0, protectEvent = 0, servoCtrlReady = 1, forcedStopPin = 1;
   logic freeRunPin = 0, mainPowerPin = 1, otPosPin = 1, otNegPin = 1, reqServoOn = 1, reqAlarmClear = 0;
   logic servoOnPin, alarmResetPin;
   logic [3:0] seqEntry;
   logic seqStart = 0, pulseRatioOn = 0, homingRun = 0;
   logic [3:0] startAddr = 0;
   int   fail_count = 0, total_checks = 0, seed = 35654, n, m, sp, sa, msi, sel, lim, ex = 0;
   // Bench copy of the written registers, indexed by word
   int   rg[0:15];

   always #5 clock = ~clock;

   ssof_status_flags #(.NC_HOLD_CYC(20)) i_ssof_status_flags (.clock(clock), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .motion(mot), .ctrlMode(mode), .multistepSpeed(ms), .teachActive(teachActive),
      .teachWritten(teachWritten), .protectEvent(protectEvent), .servoCtrlReady(servoCtrlReady),
      .seqStart(seqStart), .startAddr(startAddr), .pulseRatioOn(pulseRatioOn), .homingRun(homingRun),
      .servoOnPin(servoOnPin),
      .forcedStopPin(forcedStopPin), .freeRunPin(freeRunPin), .mainPowerPin(mainPowerPin),
      .alarmResetPin(alarmResetPin), .otPosPin(otPosPin), .otNegPin(otNegPin), .flags(flags),
      .limitStop(limitStop), .seqEntry(seqEntry));

   ssof_host_model i_ssof_host_model (.clock(clock), .rst(rst), .reqServoOn(reqServoOn),
      .reqAlarmClear(reqAlarmClear), .alarmSeen(flags.alarmNo), .servoOnPin(servoOnPin),
      .alarmResetPin(alarmResetPin));

   task st(input int c);
      repeat (c) @(posedge clock);
   endtask

   task ck(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      n = 0;
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge clock);
         n++;
      end
      ck("pready", 1, pready);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (w && a <= `SSOF_A_ENDMARK)
         rg[a[5:2]] = d;
   endtask

   task tend(input string nm);
      $display("test %s done", nm);
   endtask

   // One start pulse; address zero means next entry
   task sq(input int a);
      seqStart  <= 1'b1;
      startAddr <= a[3:0];
      st(1);
      seqStart  <= 1'b0;
      st(3);
      ex = (a != 0) ? a : ((ex < 15) ? ex + 1 : 15);
   endtask

   task close_out;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Sized well above the sequence length
   initial
   begin
      st(20000);
      fail_count++;
      close_out();
   end

   initial
   begin
      st(4);
      rst <= 1'b0;
      st(2);
      ck("alarmNc", 0, flags.alarmNc);
      st(30);
      ck("alarmNc", 1, flags.alarmNc);
      tend("holdoff");
      apb(1, `SSOF_A_BRKDLY, 0);
      apb(1, `SSOF_A_SOT, 32'h7fff_0000);
      apb(1, `SSOF_A_SPDLIM, 150);
      apb(1, `SSOF_A_TQSPD, 200);
      apb(1, `SSOF_A_ZSPD, 20);
      apb(1, `SSOF_A_ZWIDTH, 5);
      apb(0, 32'h0000_0040, 0);
      ck("pslverr", 1, err);
      ck("rdata", 0, rd);
      apb(0, `SSOF_A_SPDLIM, 0);
      ck("rdata", rg[1], rd);
      tend("bus");
      st(8);
      ck("ready", 1, flags.ready);
      ck("brake", 1, flags.brake);
      freeRunPin <= 1'b1;
      st(8);
      ck("ready", 0, flags.ready);
      freeRunPin <= 1'b0;
      st(8);
      protectEvent <= 1'b1;
      st(1);
      protectEvent <= 1'b0;
      st(2);
      ck("alarmNo", 1, flags.alarmNo);
      ck("drop", 0, {flags.baseEnable, flags.ready, flags.brake});
      st(10);
      ck("alarmNc", 0, flags.alarmNc);
      reqAlarmClear <= 1'b1;
      for (m = 0; m < 40 && flags.alarmNo !== 1'b0; m++)
         st(1);
      ck("alarmNo", 0, flags.alarmNo);
      reqAlarmClear <= 1'b0;
      st(8);
      ck("ready", 1, flags.ready);
      tend("alarm");
      reqServoOn <= 1'b0;
      st(10);
      ck("servoOff", 0, {flags.ready, flags.brake});
      reqServoOn <= 1'b1;
      st(8);
      mainPowerPin <= 1'b0;
      st(8);
      ck("powerOff", 0, {flags.baseEnable, flags.ready, flags.brake});
      mainPowerPin <= 1'b1;
      st(8);
      tend("power");
      // Random speed, mode and limit source
      for (int i = 0; i < 12; i++)
      begin
         sel = $unsigned($random(seed)) % 2;
         m   = $unsigned($random(seed)) % 3;
         sp  = $random(seed) % 300;
         msi = $unsigned($random(seed)) % 300;
         apb(1, `SSOF_A_CTRL, sel);
         mode <= ssof_pkg::ssof_mode_t'(m[1:0]);
         mot.speed <= sp[15:0];
         ms <= msi[15:0];
         st(3);
         sa  = sp < 0 ? -sp : sp;
         lim = (m == 2) ? (sel ? msi : rg[2]) : rg[1];
         ck("speedLimit", sa >= lim, flags.speedLimit);
         ck("zeroSpeed", sa <= rg[4], flags.zeroSpeed);
      end
      tend("speed");
      mode <= ssof_pkg::CM_POSITION;
      mot.command <= 1000;
      mot.position <= 1003;
      st(3);
      ck("zeroDev", 1, flags.zeroDev);
      mot.position <= 1010;
      st(3);
      ck("zeroDev", 0, flags.zeroDev);
      mode <= ssof_pkg::CM_SPEED;
      mot.position <= 1002;
      st(3);
      ck("zeroDevHeld", 0, flags.zeroDev);
      mode <= ssof_pkg::CM_POSITION;
      apb(1, `SSOF_A_HOME, 1000);
      apb(1, `SSOF_A_HRANGE, 10);
      apb(1, `SSOF_A_PT1, 500);
      apb(1, `SSOF_A_PT2, 1500);
      apb(1, `SSOF_A_CTRL, 32'h2);
      mot.homed <= 1'b1;
      mot.position <= 1005;
      st(3);
      ck("homeDone", 1, flags.homeDone);
      ck("areaPos", 2'b10, {flags.area1, flags.area2});
      apb(1, `SSOF_A_CTRL, 32'h4);
      st(3);
      ck("areaNeg", 2'b01, {flags.area1, flags.area2});
      apb(1, `SSOF_A_PTW, 10);
      apb(1, `SSOF_A_CTRL, 32'h0);
      mot.position <= 1495;
      st(3);
      ck("areaPoint", 2'b01, {flags.area1, flags.area2});
      mot.position <= 2000;
      st(3);
      ck("homeDone", 0, flags.homeDone);
      apb(1, `SSOF_A_HRANGE, 0);
      st(3);
      ck("homeDone", 1, flags.homeDone);
      mot.homed <= 1'b0;
      st(3);
      ck("areaOff", 0, {flags.area1, flags.area2});
      tend("position");
      mot.moving <= 1'b1;
      mot.dirPos <= 1'b1;
      otPosPin <= 1'b0;
      st(8);
      ck("overtravel", 1, flags.overtravel);
      mot.dirPos <= 1'b0;
      st(8);
      ck("overtravel", 0, flags.overtravel);
      otNegPin <= 1'b0;
      st(8);
      ck("overtravel", 1, flags.overtravel);
      otPosPin <= 1'b1;
      otNegPin <= 1'b1;
      teachActive <= 1'b1;
      teachWritten <= 1'b1;
      st(3);
      ck("overwrite", 1, flags.overwrite);
      teachWritten <= 1'b0;
      st(3);
      ck("overwrite", 1, flags.overwrite);
      teachActive <= 1'b0;
      st(3);
      ck("overwrite", 0, flags.overwrite);
      tend("travel");
      apb(1, `SSOF_A_ENDMARK, 32'h20);
      apb(1, `SSOF_A_CTRL, 32'h8);
      mot.inPosition <= 1'b1;
      sq(5);
      ck("cycleEndOff", 0, flags.cycleEnd);
      apb(1, `SSOF_A_CTRL, 32'h18);
      sq(3);
      ck("seqEntry", ex, seqEntry);
      sq(0);
      ck("seqEntry", ex, seqEntry);
      ck("cycleEnd", 0, flags.cycleEnd);
      sq(0);
      ck("seqEntry", ex, seqEntry);
      ck("cycleEnd", 1, flags.cycleEnd);
      homingRun <= 1'b1;
      st(3);
      ck("cycleEndHoming", 0, flags.cycleEnd);
      homingRun <= 1'b0;
      pulseRatioOn <= 1'b1;
      st(3);
      ck("cycleEndRatio", 0, flags.cycleEnd);
      pulseRatioOn <= 1'b0;
      sq(15);
      sq(0);
      ck("seqEntry", ex, seqEntry);
      ck("cycleEnd15", 1, flags.cycleEnd);
      tend("sequence");
      apb(1, `SSOF_A_SOT, 3000);
      mot.homed <= 1'b1;
      mot.pulseOp <= 1'b1;
      mot.intPos <= 1'b1;
      mot.dirPos <= 1'b1;
      mot.position <= 3000;
      st(3);
      ck("limitStopInt", 0, limitStop);
      mot.intPos <= 1'b0;
      st(3);
      ck("limitStop", 1, limitStop);
      ck("rapidDecel", 1, flags.rapidDecel);
      ck("limiter", 1, flags.limiter);
      ck("softOt", 1, flags.overtravel);
      mot.dirPos <= 1'b0;
      st(3);
      ck("limiter", 0, flags.limiter);
      ck("limitStop", 0, limitStop);
      tend("limiter");
      close_out();
   end
endmodule // tb_top
